// ---- fpc_pkg.sv ----
package fpc_pkg;

	// bus
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_FAN_CHAR = 6'h20;
	localparam logic [5:0] IDX_FLOOR_DUTY = 6'h21;
	localparam logic [5:0] IDX_LOCAL_CURVE = 6'h24;
	localparam logic [5:0] IDX_REMOTE_CURVE = 6'h25;
	localparam logic [5:0] IDX_CONTROL = 6'h26;
	localparam logic [5:0] IDX_STATUS = 6'h27;

	// reset values
	localparam logic [7:0] RST_FAN_CHAR = 8'h1D;
	localparam logic [7:0] RST_FLOOR_DUTY = 8'h55;
	localparam logic [7:0] RST_LOCAL_CURVE = 8'h41;
	localparam logic [7:0] RST_REMOTE_CURVE = 8'h61;
	localparam logic [15:0] RST_CONTROL = 16'h5501;

	// fan characteristics fields
	localparam int FC_SPINUP_DIS_BIT = 7;
	localparam int FC_FREQ_LSB = 3;
	localparam int FC_STIME_LSB = 0;
	localparam logic [7:0] FC_WRITE_MASK = 8'hBF;

	// curve register fields
	localparam int CURVE_THR_LSB = 3;
	localparam int CURVE_SLOPE_LSB = 0;
	localparam int THR_STEP_SHIFT = 2;
	localparam logic [2:0] SLOPE_MAX_CODE = 3'h4;
	localparam int SLOPE_TOP_SHIFT = 5;

	// control / status fields
	localparam int CTL_AUTO_BIT = 0;
	localparam int CTL_REMOTE_BIT = 1;
	localparam int CTL_MANUAL_LSB = 8;
	localparam logic [15:0] CTL_WRITE_MASK = 16'hFF03;
	localparam int ST_SPIN_BIT = 8;
	localparam int ST_HIGH_BIT = 9;

	localparam logic [7:0] DUTY_FULL = 8'hFF;
	localparam logic [7:0] DUTY_ZERO = 8'h00;

	// clocks
	localparam int MCLK_HZ = 25_000_000;
	localparam int INT_HZ = 3_200_000;
	localparam int SPINUP_BASE_MS = 200;

	// pwm period in internal ticks, up to 320000
	localparam int PERIOD_W = 19;

	typedef logic [PERIOD_W-1:0] fpc_period_t;

	localparam int HIGH_HZ [8] = '{1000, 10000, 20000, 25000, 30000, 40000, 40000, 40000};
	localparam int LOW_HZ [8] = '{10, 15, 23, 30, 38, 47, 62, 94};

	// spin-up time in units of the base interval
	localparam int SPIN_UNITS [8] = '{1, 2, 3, 4, 5, 10, 20, 40};

	function automatic fpc_period_t fpc_period(input logic highRange, input logic [2:0] code);
		int hz;
		hz = highRange ? HIGH_HZ[code] : LOW_HZ[code];
		return fpc_period_t'(INT_HZ / hz);
	endfunction

endpackage

// ---- fpc_pwm_core.sv ----
`timescale 1ns/1ps
`default_nettype none

module fpc_pwm_core #(
	parameter int CNT_W = fpc_pkg::PERIOD_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// internal clock tick
	input wire logic intTick,
	// settings
	input wire logic [CNT_W-1:0] periodTicks,
	input wire logic [7:0] dutyValue,
	// fan
	output logic pwmOut
);
	import fpc_pkg::*;

	localparam int PROD_W = CNT_W + 8;

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] period_q;
	logic [7:0] duty_q;
	logic [PROD_W-1:0] lhs;
	logic [PROD_W-1:0] rhs;

	// high while cnt/period < duty/255, so 0xFF is full on
	assign lhs = PROD_W'(cnt_q) * PROD_W'(DUTY_FULL);
	assign rhs = PROD_W'(duty_q) * PROD_W'(period_q);

	// settings latched only at period start, so no runt pulses
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= '0;
			period_q <= '0;
			duty_q <= DUTY_ZERO;
		end else if (intTick) begin
			if (cnt_q + CNT_W'(1) >= period_q) begin
				cnt_q <= '0;
				period_q <= periodTicks;
				duty_q <= dutyValue;
			end else begin
				cnt_q <= cnt_q + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pwmOut <= 1'b0;
		end else begin
			pwmOut <= (period_q != '0) && (lhs < rhs);
		end
	end

endmodule

`default_nettype wire

// ---- fpc_fan_ctrl.sv ----
// Function
// - 3-bit code picks PWM frequency within high or low range
// - PWM timing comes from a 3.2 MHz internal tick
// - range pin at ground selects high range, otherwise low range
// - spin-up drives full duty for the coded spin-up time
// - spin-up time code ignored while spin-up disable bit is one
// - 8-bit floor duty register, reset 0x55
// - local auto: duty equals floor at or below local threshold
// - local threshold is code times 4 degrees, 0 to 124, default 32
// - local slope codes 0..4 give 32,16,8,4,2 LSB per degree
// - local curve register: threshold 7:3, slope 2:0, reset 0x41
// - remote threshold is code times 4 degrees, default 48
// - remote auto: duty equals floor at or below remote threshold
// - remote slope uses same five encodings, default 16 LSB
// - remote curve register: threshold 7:3, slope 2:0, reset 0x61
// - high range codes give 1,10,20,25,30,40,40,40 kHz
// - spin-up disable bit zero enables spin-up, reset zero
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module fpc_fan_ctrl #(
	parameter int SPINUP_BASE_CYCLES = fpc_pkg::SPINUP_BASE_MS * (fpc_pkg::MCLK_HZ / 1000)
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [fpc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [fpc_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [fpc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [fpc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// temperatures, whole degrees, same clock
	input wire logic [7:0] localTemp,
	input wire logic [7:0] remoteTemp,
	// range select pin, asynchronous
	input wire logic pwmModePin,
	// fan
	output logic pwmOut,
	output logic spinupActive
);
	import fpc_pkg::*;

	localparam int SUM_W = 14;
	localparam int SPIN_W = 32;

	// registers
	logic [7:0] fanChar_q;
	logic [7:0] floor_duty_reg_q;
	logic [7:0] localCurve_q;
	logic [7:0] remoteCurve_q;
	logic [15:0] control_q;

	// fields
	logic spinup_disable;
	logic [2:0] pwm_freq_code;
	logic [2:0] spinup_time_code;
	logic [4:0] local_low_threshold;
	logic [2:0] local_slope_code;
	logic [4:0] remote_low_threshold;
	logic [2:0] remote_slope_code;
	logic autoEnable;
	logic useRemote;
	logic [7:0] manualDuty;

	// bus state
	logic awHeld_q;
	logic wHeld_q;
	logic [5:0] awIdx_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic doWrite;
	logic wrHit;
	logic [5:0] arIdx;

	// pin sync
	logic modeSync1_q;
	logic modeSync2_q;
	logic highRange;

	// internal tick
	logic [24:0] phase_q;
	logic intTick_q;

	// duty path
	logic [7:0] localDuty;
	logic [7:0] remoteDuty;
	logic [7:0] targetDuty;
	logic [7:0] duty_cycle_value;
	logic [7:0] dutyOut_q;
	logic prevZero_q;
	logic [SPIN_W-1:0] spinCnt_q;
	logic spinStart;
	fpc_period_t periodTicks;

	assign spinup_disable = fanChar_q[FC_SPINUP_DIS_BIT];
	assign pwm_freq_code = fanChar_q[FC_FREQ_LSB +: 3];
	assign spinup_time_code = fanChar_q[FC_STIME_LSB +: 3];
	assign local_low_threshold = localCurve_q[CURVE_THR_LSB +: 5];
	assign local_slope_code = localCurve_q[CURVE_SLOPE_LSB +: 3];
	assign remote_low_threshold = remoteCurve_q[CURVE_THR_LSB +: 5];
	assign remote_slope_code = remoteCurve_q[CURVE_SLOPE_LSB +: 3];
	assign autoEnable = control_q[CTL_AUTO_BIT];
	assign useRemote = control_q[CTL_REMOTE_BIT];
	assign manualDuty = control_q[CTL_MANUAL_LSB +: 8];

	// range pin: two flops before use
	always_ff @(posedge mclk) begin
		if (rst) begin
			modeSync1_q <= 1'b1;
			modeSync2_q <= 1'b1;
		end else begin
			modeSync1_q <= pwmModePin;
			modeSync2_q <= modeSync1_q;
		end
	end

	// a floating pin reads high, so only a solid low picks high range
	assign highRange = ~modeSync2_q;

	// fractional divider: 25 MHz has no integer ratio to 3.2 MHz,
	// so ticks jitter by one mclk but average exactly
	always_ff @(posedge mclk) begin
		if (rst) begin
			phase_q <= '0;
			intTick_q <= 1'b0;
		end else if (phase_q + 25'(INT_HZ) >= 25'(MCLK_HZ)) begin
			phase_q <= phase_q + 25'(INT_HZ) - 25'(MCLK_HZ);
			intTick_q <= 1'b1;
		end else begin
			phase_q <= phase_q + 25'(INT_HZ);
			intTick_q <= 1'b0;
		end
	end

	assign periodTicks = fpc_period(highRange, pwm_freq_code);

	// auto curve for one sensor
	function automatic logic [7:0] curve_duty(
		input logic [7:0] temp,
		input logic [4:0] thrCode,
		input logic [2:0] slopeCode,
		input logic [7:0] floorDuty
	);
		logic [7:0] thr;
		logic [7:0] excess;
		logic [2:0] shift;
		logic [SUM_W-1:0] sum;
		thr = 8'(thrCode) << THR_STEP_SHIFT;
		excess = temp - thr;
		if (slopeCode > SLOPE_MAX_CODE) begin
			shift = 3'd1;
		end else begin
			shift = 3'(SLOPE_TOP_SHIFT) - slopeCode;
		end
		sum = SUM_W'(floorDuty) + (SUM_W'(excess) << shift);
		if (temp <= thr) begin
			return floorDuty;
		end else if (sum > SUM_W'(DUTY_FULL)) begin
			return DUTY_FULL;
		end else begin
			return sum[7:0];
		end
	endfunction

	assign localDuty = curve_duty(localTemp, local_low_threshold, local_slope_code,
		floor_duty_reg_q);
	assign remoteDuty = curve_duty(remoteTemp, remote_low_threshold, remote_slope_code,
		floor_duty_reg_q);

	always_comb begin
		if (!autoEnable) begin
			targetDuty = manualDuty;
		end else if (useRemote) begin
			targetDuty = remoteDuty;
		end else begin
			targetDuty = localDuty;
		end
	end

	// spin-up fires when the fan goes from stopped to running
	assign spinStart = prevZero_q && (targetDuty != DUTY_ZERO) && !spinup_disable;

	always_ff @(posedge mclk) begin
		if (rst) begin
			prevZero_q <= 1'b1;
		end else begin
			prevZero_q <= (targetDuty == DUTY_ZERO);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			spinCnt_q <= '0;
		end else if (spinup_disable) begin
			spinCnt_q <= '0;
		end else if (spinStart) begin
			spinCnt_q <= SPIN_W'(SPIN_UNITS[spinup_time_code]) * SPIN_W'(SPINUP_BASE_CYCLES);
		end else if (spinCnt_q != '0) begin
			spinCnt_q <= spinCnt_q - SPIN_W'(1);
		end
	end

	// full duty while spinning up
	assign duty_cycle_value = (spinCnt_q != '0) ? DUTY_FULL : targetDuty;

	always_ff @(posedge mclk) begin
		if (rst) begin
			dutyOut_q <= DUTY_ZERO;
			spinupActive <= 1'b0;
		end else begin
			dutyOut_q <= duty_cycle_value;
			spinupActive <= (spinCnt_q != '0);
		end
	end

	fpc_pwm_core #(
		.CNT_W(PERIOD_W)
	) u_pwm (
		.mclk(mclk),
		.rst(rst),
		.intTick(intTick_q),
		.periodTicks(periodTicks),
		.dutyValue(dutyOut_q),
		.pwmOut(pwmOut)
	);

	// write channel: address and data taken in either order
	assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

	always_comb begin
		case (awIdx_q)
			IDX_FAN_CHAR, IDX_FLOOR_DUTY, IDX_LOCAL_CURVE,
			IDX_REMOTE_CURVE, IDX_CONTROL, IDX_STATUS: begin
				wrHit = 1'b1;
			end
			default: begin
				wrHit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			awIdx_q <= '0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_q <= 1'b1;
			awIdx_q <= s_axi_awaddr[7:2];
			s_axi_awready <= 1'b0;
		end else begin
			if (doWrite) begin
				awHeld_q <= 1'b0;
			end
			s_axi_awready <= !awHeld_q && !s_axi_bvalid;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wHeld_q <= 1'b0;
			wData_q <= '0;
			wStrb_q <= '0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_q <= 1'b1;
			wData_q <= s_axi_wdata;
			wStrb_q <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else begin
			if (doWrite) begin
				wHeld_q <= 1'b0;
			end
			s_axi_wready <= !wHeld_q && !s_axi_bvalid;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wrHit && awIdx_q != IDX_STATUS) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register file; narrow registers use byte lane 0 only
	always_ff @(posedge mclk) begin
		if (rst) begin
			fanChar_q <= RST_FAN_CHAR;
			floor_duty_reg_q <= RST_FLOOR_DUTY;
			localCurve_q <= RST_LOCAL_CURVE;
			remoteCurve_q <= RST_REMOTE_CURVE;
			control_q <= RST_CONTROL;
		end else if (doWrite) begin
			if (wStrb_q[0]) begin
				case (awIdx_q)
					IDX_FAN_CHAR: begin
						fanChar_q <= wData_q[7:0] & FC_WRITE_MASK;
					end
					IDX_FLOOR_DUTY: begin
						floor_duty_reg_q <= wData_q[7:0];
					end
					IDX_LOCAL_CURVE: begin
						localCurve_q <= wData_q[7:0];
					end
					IDX_REMOTE_CURVE: begin
						remoteCurve_q <= wData_q[7:0];
					end
					IDX_CONTROL: begin
						control_q[7:0] <= wData_q[7:0] & CTL_WRITE_MASK[7:0];
					end
					default: begin
					end
				endcase
			end
			if (wStrb_q[1] && awIdx_q == IDX_CONTROL) begin
				control_q[15:8] <= wData_q[15:8];
			end
		end
	end

	// read channel
	assign arIdx = s_axi_araddr[7:2];

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (arIdx)
				IDX_FAN_CHAR: begin
					s_axi_rdata <= 32'(fanChar_q);
				end
				IDX_FLOOR_DUTY: begin
					s_axi_rdata <= 32'(floor_duty_reg_q);
				end
				IDX_LOCAL_CURVE: begin
					s_axi_rdata <= 32'(localCurve_q);
				end
				IDX_REMOTE_CURVE: begin
					s_axi_rdata <= 32'(remoteCurve_q);
				end
				IDX_CONTROL: begin
					s_axi_rdata <= 32'(control_q);
				end
				IDX_STATUS: begin
					s_axi_rdata <= 32'({highRange, spinupActive, dutyOut_q});
				end
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// ---- fpc_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpc_props #(
	parameter int SPINUP_BASE_CYCLES = fpc_pkg::SPINUP_BASE_MS * (fpc_pkg::MCLK_HZ / 1000)
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [fpc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	// fan
	input wire logic pwmOut,
	input wire logic spinupActive
);
	import fpc_pkg::*;
	int spinCnt_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// run length of the current spin-up
	always_ff @(posedge mclk) begin
		if (rst || !spinupActive) spinCnt_q <= 0;
		else spinCnt_q <= spinCnt_q + 1;
	end
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// both halves held for one edge, response registered on the next
	property p_b_answer;
		s_wr_taken |-> ##2 s_axi_bvalid;
	endproperty
	property p_b_stands;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_w_refused;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_r_answer;
		s_rd_taken |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	property p_r_stands;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_r_release;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready;
	endproperty
	// longest coded spin-up is 40 base intervals
	property p_spin_max;
		spinCnt_q <= 40 * SPINUP_BASE_CYCLES;
	endproperty
	property p_spin_boot;
		$fell(rst) |-> ##[0:2] spinupActive;
	endproperty
	// reset itself is the antecedent, so no disable here
	property p_rst_quiet;
		disable iff (1'b0) rst |=> !s_axi_bvalid && !s_axi_rvalid && !spinupActive && !pwmOut;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("no write response");
	a_b_stands: assert property (p_b_stands) else $error("write response dropped");
	a_w_refused: assert property (p_w_refused) else $error("write taken while busy");
	a_r_answer: assert property (p_r_answer) else $error("no read response");
	a_r_stands: assert property (p_r_stands) else $error("read data dropped");
	a_r_release: assert property (p_r_release) else $error("read not released");
	a_spin_max: assert property (p_spin_max) else $error("spin-up too long");
	a_spin_boot: assert property (p_spin_boot) else $error("no spin-up at start");
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
endmodule
bind fpc_fan_ctrl fpc_props #(.SPINUP_BASE_CYCLES(SPINUP_BASE_CYCLES)) u_props (
	.mclk(mclk),
	.rst(rst),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata),
	.pwmOut(pwmOut),
	.spinupActive(spinupActive)
);
`default_nettype wire

// ---- fpc_fan_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpc_fan_model (
	// drive from controller
	input wire logic pwmIn,
	// measurements
	output var int periodNs,
	output var int highNs,
	output var int rises
);
	longint tRise;
	// a fan only sees rising edges as period starts
	initial begin
		periodNs = 0;
		highNs = 0;
		rises = 0;
		tRise = 0;
	end
	always @(posedge pwmIn) begin
		periodNs = int'($time - tRise);
		tRise = $time;
		rises++;
	end
	always @(negedge pwmIn) begin
		highNs = int'($time - tRise);
	end
endmodule
`default_nettype wire

// ---- fpc_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb;
	import fpc_pkg::*;
	localparam int BASE = 20;
	localparam logic [7:0] A_FC = 8'h80, A_FL = 8'h84, A_LO = 8'h90;
	localparam logic [7:0] A_RE = 8'h94, A_CT = 8'h98, A_ST = 8'h9C;
	localparam logic [7:0] RA [4] = '{8'h80, 8'h84, 8'h90, 8'h94};
	localparam logic [31:0] RV [4] = '{32'h1D, 32'h55, 32'h41, 32'h61};
	localparam int HZ [8] = '{1000, 10000, 20000, 25000, 30000, 40000, 40000, 40000};
	localparam int UNITS [8] = '{1, 2, 3, 4, 5, 10, 20, 40};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00, localTemp = 8'h20, remoteTemp = 8'h30;
	logic [31:0] wData = 32'h0;
	logic pwmModePin = 1'b0;
	logic awReady, wReady, bValid, arReady, rValid, pwmOut, spinupActive;
	logic [1:0] bResp, rResp;
	logic [31:0] rData;
	int fail_count = 0, n_compared = 0, spinCyc = 0, periodNs, highNs, rises;
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		if (spinupActive === 1'b1) spinCyc++;
	end
	fpc_fan_ctrl #(.SPINUP_BASE_CYCLES(BASE)) u_dut (
		.mclk(mclk), .rst(rst),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hF), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
		.s_axi_arprot(3'h0), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .localTemp(localTemp), .remoteTemp(remoteTemp),
		.pwmModePin(pwmModePin), .pwmOut(pwmOut), .spinupActive(spinupActive)
	);
	fpc_fan_model u_fan (.pwmIn(pwmOut), .periodNs(periodNs), .highNs(highNs), .rises(rises));
	function automatic int absd(input int v);
		return v < 0 ? -v : v;
	endfunction
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// each channel released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (awReady === 1'b1) awValid <= 1'b0;
			if (wReady === 1'b1) wValid <= 1'b0;
		end while (bValid !== 1'b1 && n < 50);
		`CHK({n < 50, bResp}, {1'b1, er})
		bReady <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd_is(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		int n;
		n = 0;
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (arReady === 1'b1) arValid <= 1'b0;
		end while (rValid !== 1'b1 && n < 50);
		`CHK({n < 50, rData & m, rResp}, {1'b1, e, er})
		rReady <= 1'b0;
		@(posedge mclk);
	endtask
	// one edge lets a new temperature reach the duty register, the task waits two
	task automatic duty_is(input logic [7:0] e);
		repeat (2) @(posedge mclk);
		rd_is(A_ST, 32'hFF, {24'h0, e}, RESP_OKAY);
	endtask
	task automatic spin_is(input int e);
		int n;
		n = 0;
		repeat (4) @(posedge mclk);
		while (spinupActive === 1'b1 && n < 1000) begin
			@(posedge mclk);
			n++;
		end
		`CHK(spinCyc, e)
	endtask
	// manual duty 0 then nonzero starts a spin-up
	task automatic kick;
		spinCyc = 0;
		wr(A_CT, 32'h0, RESP_OKAY);
		wr(A_CT, 32'h8000, RESP_OKAY);
	endtask
	task automatic t_regs;
		for (int i = 0; i < 4; i++) rd_is(RA[i], 32'hFFFF_FFFF, RV[i], RESP_OKAY);
		rd_is(8'h40, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
		wr(A_ST, 32'h0, RESP_SLVERR);
	endtask
	task automatic t_spin;
		wr(A_FC, 32'h9D, RESP_OKAY);
		kick();
		spin_is(0);
		for (int c = 0; c < 8; c++) begin
			wr(A_FC, 32'h18 | 32'(c), RESP_OKAY);
			kick();
			spin_is(BASE * UNITS[c]);
		end
		wr(A_CT, 32'h1, RESP_OKAY);
	endtask
	task automatic t_local;
		wr(A_FL, 32'h40, RESP_OKAY);
		duty_is(8'h40);
		localTemp <= 8'h21;
		for (int c = 0; c < 8; c++) begin
			wr(A_LO, 32'h40 | 32'(c), RESP_OKAY);
			duty_is(8'h40 + (c < 5 ? 8'(32 >> c) : 8'h02));
		end
		localTemp <= 8'h28;
		wr(A_LO, 32'h40, RESP_OKAY);
		duty_is(8'hFF);
		wr(A_LO, 32'hFC, RESP_OKAY);
		localTemp <= 8'h7C;
		duty_is(8'h40);
		localTemp <= 8'h7D;
		duty_is(8'h42);
	endtask
	task automatic t_remote;
		wr(A_CT, 32'h3, RESP_OKAY);
		duty_is(8'h40);
		remoteTemp <= 8'h31;
		duty_is(8'h50);
		wr(A_RE, 32'h64, RESP_OKAY);
		remoteTemp <= 8'h33;
		duty_is(8'h46);
		wr(A_RE, 32'hF8, RESP_OKAY);
		remoteTemp <= 8'h7D;
		duty_is(8'h60);
		remoteTemp <= 8'h30;
	endtask
	// slowest code last, it alone costs most of the run
	task automatic t_freq;
		int t, r0, n;
		for (int c = 7; c >= 0; c--) begin
			wr(A_FC, 32'h80 | 32'(c << 3), RESP_OKAY);
			r0 = rises;
			n = 0;
			while (rises < r0 + 3 && n < 80000) begin
				@(posedge mclk);
				n++;
			end
			t = 3200000 / HZ[c];
			`CHK(absd(periodNs - t * 3125 / 10) < 100, 1'b1)
			`CHK(absd(highNs - (64 * t + 254) / 255 * 3125 / 10) < 100, 1'b1)
		end
	endtask
	task automatic t_pin;
		rd_is(A_ST, 32'h200, 32'h200, RESP_OKAY);
		pwmModePin <= 1'b1;
		repeat (4) @(posedge mclk);
		rd_is(A_ST, 32'h200, 32'h0, RESP_OKAY);
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		spin_is(10 * BASE);
		t_regs();
		t_spin();
		t_local();
		t_remote();
		t_freq();
		t_pin();
		wrap_up();
	end
	initial begin
		// slowest frequency code dominates; whole run is near 76k cycles
		repeat (95000) @(posedge mclk);
		fail_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
